// ===== emc_pkg.sv
// constants for the ethernet mac control register slice
package emc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTL = 8'h00;
   localparam logic [7:0] OFS_CFG = 8'h04;
   localparam logic [7:0] OFS_SR = 8'h08;
   localparam logic [7:0] OFS_TAR = 8'h0C;
   localparam logic [7:0] OFS_TCR = 8'h10;
   localparam logic [7:0] OFS_TSR = 8'h14;
   localparam logic [7:0] OFS_RBQP = 8'h18;
   // ---------------------------------------------------------------
   // reset values and writable masks
   // ---------------------------------------------------------------
   localparam logic [31:0] CTL_RST = 32'h0000_0000;
   localparam logic [31:0] CTL_MASK = 32'h0000_019F;
   localparam logic [31:0] CFG_RST = 32'h0000_0800;
   localparam logic [31:0] CFG_MASK = 32'h0000_3FF7;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [31:0] WORD_ALIGN = 32'hFFFF_FFFC;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CTL_STAT_WR = 7;
   localparam int CTL_BACKP = 8;
   localparam int CFG_SPD = 0;
   localparam int CFG_DUPLEX = 1;
   localparam int CFG_COPY_ALL = 4;
   localparam int CFG_NO_BCAST = 5;
   localparam int CFG_MC_HASH = 6;
   localparam int CFG_UC_HASH = 7;
   localparam int CFG_LONG = 8;
   localparam int CFG_CLK_LSB = 10;
   localparam int CFG_RETRY = 12;
   localparam int CFG_RMII = 13;
   localparam int SR_MDIO = 1;
   localparam int SR_IDLE = 2;
   localparam int TCR_OWN_CRC = 15;
   localparam int TXLEN_W = 11;
   localparam int TSR_OVERRUN = 0;
   localparam int TSR_COL = 1;
   localparam int TSR_RETRY = 2;
   localparam int TSR_IDLE = 3;
   localparam int TSR_FREE = 4;
   localparam int TSR_COMP = 5;
   localparam int TSR_UNDER = 6;
   // ---------------------------------------------------------------
   // frame sizes and timing counts
   // ---------------------------------------------------------------
   localparam logic [10:0] TX_MAX_CRC = 11'd1514;
   localparam logic [10:0] TX_MAX_NOCRC = 11'd1518;
   localparam logic [10:0] RX_MAX_STD = 11'd1518;
   localparam logic [10:0] RX_MAX_LONG = 11'd1522;
   localparam logic [6:0] JAM_BITS = 7'd64;
   localparam int TX_START_WORDS = 2;
   localparam logic [1:0] MDC_CLK_RST = 2'b10;
   localparam logic [5:0] MDC_HALF_BASE = 6'd4;
   // ---------------------------------------------------------------
   // transmit queue states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      TQ_IDLE = 3'b001,
      TQ_BUSY = 3'b010,
      TQ_QUEUED = 3'b100
   } emc_txq_type;
endpackage

// ===== emc_mdc_div.sv
// management clock divider, system clock over 8, 16, 32 or 64
`timescale 1ns/1ps
module emc_mdc_div (
   input wire logic ref_clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic ce, // clock enable
   input wire logic [1:0] div_code, // divider select
   output logic mdc // management clock out
);
   import emc_pkg::*;
   logic [5:0] cnt_r;
   logic mdc_r;
   wire [5:0] half_lim = (MDC_HALF_BASE << div_code) - 6'd1;
   wire wrap = (cnt_r >= half_lim);
   // code change takes effect at once, within the half period already running
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_r <= 6'd0;
         mdc_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= wrap ? 6'd0 : cnt_r + 6'd1;
         if (wrap) begin
            mdc_r <= ~mdc_r;
         end
      end
   end
   assign mdc = mdc_r;
endmodule

// ===== emc_ctrl.sv
// ethernet mac control, configuration, transmit queue and status registers
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
module emc_ctrl #(
   parameter int FIFO_W = 3 // width of the fifo word count
) (
   input wire logic ref_clk, // 200 MHz system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes all state
   input wire logic [7:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // slave stall
   input wire logic mdio_pin, // management data pin level
   input wire logic col_pin, // phy collision
   input wire logic crs_pin, // phy carrier sense
   input wire logic mgmt_busy, // management shifter running
   input wire logic [FIFO_W-1:0] tx_fifo_words, // words in transmit fifo
   input wire logic tx_frame_done, // frame finished, pulse
   input wire logic tx_retry_limit, // retry limit reached, pulse
   input wire logic tx_dma_late, // dma data late, pulse
   input wire logic rx_frame_start, // receive frame begins, pulse
   input wire logic bit_tick, // one line bit time, pulse
   input wire logic rx_da_valid, // destination decoded, pulse
   input wire logic rx_da_bcast, // destination is broadcast
   input wire logic rx_da_mcast, // destination is multicast
   input wire logic rx_da_match, // specific address hit
   input wire logic [5:0] rx_hash_idx, // crc hash index
   input wire logic [63:0] hash_bits, // hash register contents
   input wire logic rx_buf_advance, // receive dma moves on, pulse
   input wire logic [31:0] rx_buf_next, // next receive buffer pointer
   output logic mdc, // management clock
   output logic stats_write_enable, // statistics counters writable
   output logic back_pressure_jam, // send jam pattern
   output logic full_duplex, // full duplex mode
   output logic tx_defer, // carrier seen in half duplex
   output logic speed_100, // speed indication
   output logic rx_accept, // frame accepted
   output logic rx_accept_valid, // accept decision ready, pulse
   output logic [10:0] rx_len_limit, // longest receive frame
   output logic single_slot, // retry test spacing
   output logic rmii_select, // reduced interface select
   output logic [31:0] tx_buf_addr, // current frame start
   output logic [10:0] tx_frame_length, // current frame length
   output logic no_crc_append, // current frame carries own crc
   output logic tx_go, // transmitter may send
   output logic tx_oversize, // current frame is oversize
   output logic tx_bad_fcs, // corrupt the fcs
   output logic [31:0] rx_queue_ptr // current receive buffer
);
   import emc_pkg::*;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   emc_txq_type tq_r, tq_nxt;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [31:0] ctl_r;
   logic [31:0] cfg_r;
   logic [31:0] stage_addr_r;
   logic [31:0] cur_addr_r, pnd_addr_r;
   logic [10:0] cur_len_r, pnd_len_r;
   logic cur_own_crc_r, pnd_own_crc_r;
   logic overrun_r, col_r, retry_r, comp_r, under_r;
   logic [31:0] rbqp_r;
   logic [2:0] sync1_r, sync2_r;
   logic col_d_r;
   logic jam_r;
   logic [6:0] jam_cnt_r;
   logic acc_r, acc_v_r;
   logic go_r, bad_fcs_r;
   logic crs_reg_r;
   logic [10:0] lim_r;
   logic over_r;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire req = avs_read | avs_write;
   wire done = req & ~wait_r;
   wire wr = avs_write & ~wait_r;
   wire wr_ctl = wr & hit(avs_address, OFS_CTL);
   wire wr_cfg = wr & hit(avs_address, OFS_CFG);
   wire wr_tar = wr & hit(avs_address, OFS_TAR);
   wire wr_tcr = wr & hit(avs_address, OFS_TCR);
   wire wr_tsr = wr & hit(avs_address, OFS_TSR);
   wire wr_rbqp = wr & hit(avs_address, OFS_RBQP);

   // ---------------------------------------------------------------
   // pins, two stage synchronisers
   // ---------------------------------------------------------------
   wire mdio_s = sync2_r[0];
   wire col_s = sync2_r[1];
   wire crs_s = sync2_r[2];
   wire duplex = cfg_r[CFG_DUPLEX];
   wire col_evt = col_s & ~col_d_r & ~duplex;

   // ---------------------------------------------------------------
   // transmit queue
   // ---------------------------------------------------------------
   wire q_free = (tq_r != TQ_QUEUED);
   wire tx_idle = (tq_r == TQ_IDLE);
   wire [31:0] tcr_old = {16'h0000, cur_own_crc_r, 4'h0, cur_len_r};
   wire [31:0] tcr_w = be_merge(tcr_old, avs_writedata, avs_byteenable);
   wire [31:0] tar_w = be_merge(stage_addr_r, avs_writedata, avs_byteenable);
   // writes that find the queue full are dropped so the queued frame survives
   wire tar_ok = wr_tar & q_free;
   wire len_load = wr_tcr & q_free & (tcr_w[TXLEN_W-1:0] != 11'd0);
   wire overrun_set = (wr_tar | wr_tcr) & ~q_free;
   wire promote = tx_frame_done & (tq_r == TQ_QUEUED);
   wire load_cur = len_load & (tx_idle | tx_frame_done) & ~promote;
   wire load_pnd = len_load & ~load_cur;

   always_comb begin
      tq_nxt = tq_r;
      case (tq_r)
         TQ_IDLE: begin
            if (len_load) begin
               tq_nxt = TQ_BUSY;
            end
         end
         TQ_BUSY: begin
            if (len_load && !tx_frame_done) begin
               tq_nxt = TQ_QUEUED;
            end else if (tx_frame_done && !len_load) begin
               tq_nxt = TQ_IDLE;
            end
         end
         TQ_QUEUED: begin
            if (tx_frame_done) begin
               tq_nxt = TQ_BUSY;
            end
         end
         default: tq_nxt = TQ_IDLE;
      endcase
   end

   wire [10:0] tx_lim = cur_own_crc_r ? TX_MAX_NOCRC : TX_MAX_CRC;
   wire fifo_ready = (32'(tx_fifo_words) >= TX_START_WORDS);
   wire go_nxt = ~tx_idle & fifo_ready & ~tx_frame_done;

   // ---------------------------------------------------------------
   // receive address filter
   // ---------------------------------------------------------------
   wire hash_hit = hash_bits[rx_hash_idx];
   wire bc_ok = rx_da_bcast & ~cfg_r[CFG_NO_BCAST];
   wire mc_ok = rx_da_mcast & ~rx_da_bcast & hash_hit & cfg_r[CFG_MC_HASH];
   wire uc_ok = ~rx_da_mcast & ~rx_da_bcast & hash_hit & cfg_r[CFG_UC_HASH];
   wire sa_ok = rx_da_match & ~rx_da_bcast;
   wire acc_nxt = cfg_r[CFG_COPY_ALL] | bc_ok | mc_ok | uc_ok | sa_ok;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   wire [31:0] sr_val = {29'h0, mgmt_busy, mdio_s, 1'b0};
   wire [31:0] tsr_val = {25'h0, under_r, comp_r, q_free, tx_idle, retry_r, col_r, overrun_r};
   wire [31:0] rd_mux =
      hit(avs_address, OFS_CTL) ? ctl_r :
      hit(avs_address, OFS_CFG) ? cfg_r :
      hit(avs_address, OFS_SR) ? sr_val :
      hit(avs_address, OFS_TAR) ? cur_addr_r :
      hit(avs_address, OFS_TCR) ? tcr_old :
      hit(avs_address, OFS_TSR) ? tsr_val :
      hit(avs_address, OFS_RBQP) ? rbqp_r : 32'h0000_0000;

   wire [31:0] tsr_clr = wr_tsr ? be_merge(32'h0, avs_writedata, avs_byteenable) : 32'h0;

   // ---------------------------------------------------------------
   // bus slave: one wait cycle, data loaded on the first edge
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         wait_r <= ~(req & wait_r);
         if (req && wait_r) begin
            rdata_r <= avs_read ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ctl_r <= CTL_RST;
         cfg_r <= CFG_RST;
         rbqp_r <= ADDR_RST;
      end else if (ce) begin
         if (wr_ctl) begin
            ctl_r <= be_merge(ctl_r, avs_writedata, avs_byteenable) & CTL_MASK;
         end
         if (wr_cfg) begin
            cfg_r <= be_merge(cfg_r, avs_writedata, avs_byteenable) & CFG_MASK;
         end
         if (wr_rbqp) begin
            rbqp_r <= be_merge(rbqp_r, avs_writedata, avs_byteenable) & WORD_ALIGN;
         end else if (rx_buf_advance) begin
            rbqp_r <= rx_buf_next & WORD_ALIGN;
         end
      end
   end

   // ---------------------------------------------------------------
   // transmit queue registers
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         tq_r <= TQ_IDLE;
         stage_addr_r <= ADDR_RST;
         cur_addr_r <= ADDR_RST;
         pnd_addr_r <= ADDR_RST;
         cur_len_r <= 11'd0;
         pnd_len_r <= 11'd0;
         cur_own_crc_r <= 1'b0;
         pnd_own_crc_r <= 1'b0;
         go_r <= 1'b0;
      end else if (ce) begin
         tq_r <= tq_nxt;
         go_r <= go_nxt;
         if (tar_ok) begin
            stage_addr_r <= tar_w;
         end
         // length pairs with the last address written before it
         if (load_cur) begin
            cur_addr_r <= stage_addr_r;
            cur_len_r <= tcr_w[TXLEN_W-1:0];
            cur_own_crc_r <= tcr_w[TCR_OWN_CRC];
         end else if (promote) begin
            cur_addr_r <= pnd_addr_r;
            cur_len_r <= pnd_len_r;
            cur_own_crc_r <= pnd_own_crc_r;
         end
         if (load_pnd) begin
            pnd_addr_r <= stage_addr_r;
            pnd_len_r <= tcr_w[TXLEN_W-1:0];
            pnd_own_crc_r <= tcr_w[TCR_OWN_CRC];
         end
      end
   end

   // ---------------------------------------------------------------
   // sticky transmit flags, set beats clear
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         overrun_r <= 1'b0;
         col_r <= 1'b0;
         retry_r <= 1'b0;
         comp_r <= 1'b0;
         under_r <= 1'b0;
      end else if (ce) begin
         overrun_r <= overrun_set | (overrun_r & ~tsr_clr[TSR_OVERRUN]);
         col_r <= col_evt | (col_r & ~tsr_clr[TSR_COL]);
         retry_r <= tx_retry_limit | (retry_r & ~tsr_clr[TSR_RETRY]);
         comp_r <= tx_frame_done | (comp_r & ~tsr_clr[TSR_COMP]);
         under_r <= tx_dma_late | (under_r & ~tsr_clr[TSR_UNDER]);
      end
   end

   // ---------------------------------------------------------------
   // underrun fcs corruption, held to the end of the frame
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         bad_fcs_r <= 1'b0;
      end else if (ce) begin
         if (tx_dma_late && !tx_idle) begin
            bad_fcs_r <= 1'b1;
         end else if (tx_frame_done) begin
            bad_fcs_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // pin synchronisers, mdio resets high as the pin idles pulled up
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sync1_r <= 3'h1;
         sync2_r <= 3'h1;
         col_d_r <= 1'b0;
      end else if (ce) begin
         sync1_r <= {crs_pin, col_pin, mdio_pin};
         sync2_r <= sync1_r;
         col_d_r <= col_s;
      end
   end

   // ---------------------------------------------------------------
   // back pressure jam, counted in line bit times
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         jam_r <= 1'b0;
         jam_cnt_r <= 7'd0;
      end else if (ce) begin
         if (!jam_r && rx_frame_start && ctl_r[CTL_BACKP] && !duplex) begin
            jam_r <= 1'b1;
            jam_cnt_r <= 7'd0;
         end else if (jam_r && bit_tick) begin
            jam_cnt_r <= jam_cnt_r + 7'd1;
            if (jam_cnt_r == JAM_BITS - 7'd1) begin
               jam_r <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // receive accept decision
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         acc_r <= 1'b0;
         acc_v_r <= 1'b0;
      end else if (ce) begin
         acc_v_r <= rx_da_valid;
         if (rx_da_valid) begin
            acc_r <= acc_nxt;
         end
      end
   end

   // ---------------------------------------------------------------
   // management clock
   // ---------------------------------------------------------------
   emc_mdc_div u_mdc (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .div_code(cfg_r[CFG_CLK_LSB +: 2]),
      .mdc(mdc)
   );

   // ---------------------------------------------------------------
   // outputs, all from flops
   // ---------------------------------------------------------------
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign stats_write_enable = ctl_r[CTL_STAT_WR];
   assign back_pressure_jam = jam_r;
   assign full_duplex = cfg_r[CFG_DUPLEX];
   assign tx_defer = crs_reg_r;
   assign speed_100 = cfg_r[CFG_SPD];
   assign rx_accept = acc_r;
   assign rx_accept_valid = acc_v_r;
   assign rx_len_limit = lim_r;
   assign single_slot = cfg_r[CFG_RETRY];
   assign rmii_select = cfg_r[CFG_RMII];
   assign tx_buf_addr = cur_addr_r;
   assign tx_frame_length = cur_len_r;
   assign no_crc_append = cur_own_crc_r;
   assign tx_go = go_r;
   assign tx_oversize = over_r;
   assign tx_bad_fcs = bad_fcs_r;
   assign rx_queue_ptr = rbqp_r;

   // ---------------------------------------------------------------
   // registered derived outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         crs_reg_r <= 1'b0;
         lim_r <= RX_MAX_STD;
         over_r <= 1'b0;
      end else if (ce) begin
         crs_reg_r <= crs_s & ~duplex;
         lim_r <= cfg_r[CFG_LONG] ? RX_MAX_LONG : RX_MAX_STD;
         // follows the current frame registers, idle or not
         over_r <= (cur_len_r > tx_lim);
      end
   end
endmodule

// ===== emc_ctrl_properties.sv
// concurrent checks on the mac control slice ports
`timescale 1ns/1ps
module emc_ctrl_properties import emc_pkg::*; #(
   parameter int FIFO_W = 3 // fifo count width
) (
   input wire logic ref_clk, // clock
   input wire logic rst_b, // reset
   input wire logic avs_read, // read
   input wire logic avs_write, // write
   input wire logic avs_waitrequest, // stall
   input wire logic rx_da_valid, // dest decoded
   input wire logic rx_accept_valid, // decision
   input wire logic [10:0] rx_len_limit, // rx limit
   input wire logic tx_frame_done, // sent
   input wire logic tx_dma_late, // late data
   input wire logic tx_go, // sending
   input wire logic tx_bad_fcs, // corrupt fcs
   input wire logic [10:0] tx_frame_length, // length
   input wire logic no_crc_append, // own crc
   input wire logic tx_oversize, // oversize
   input wire logic [FIFO_W-1:0] tx_fifo_words, // fifo
   input wire logic full_duplex, // duplex
   input wire logic tx_defer // defer
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer not one cycle");
   a_accept_pulse: assert property (rx_da_valid |=> rx_accept_valid)
      else $error("no accept decision");
   a_len_limit: assert property ($past(rst_b) |->
      rx_len_limit == RX_MAX_STD || rx_len_limit == RX_MAX_LONG) else $error("bad rx limit");
   a_fcs_late: assert property (tx_dma_late && tx_go && !tx_frame_done |=> tx_bad_fcs)
      else $error("fcs not corrupted");
   a_fcs_clear: assert property (tx_frame_done && !tx_dma_late |=> !tx_bad_fcs)
      else $error("fcs corruption stuck");
   a_go_fifo: assert property ($rose(tx_go) |-> $past(tx_fifo_words) >= 2)
      else $error("send before two words");
   a_oversize_len: assert property ($stable(tx_frame_length) && $stable(no_crc_append)
      |-> tx_oversize == (tx_frame_length > (no_crc_append ? TX_MAX_NOCRC : TX_MAX_CRC)))
      else $error("oversize wrong");
   a_fd_defer: assert property (full_duplex && $past(full_duplex) |-> !tx_defer)
      else $error("defer in full duplex");
endmodule
bind emc_ctrl emc_ctrl_properties #(.FIFO_W(FIFO_W)) chk_i (.*);

// ===== emc_phy_model.sv
// phy side model: carrier, collision and management data pin
`timescale 1ns/1ps
module emc_phy_model (
   input wire logic ref_clk, // system clock
   input wire logic crs_req, // bench asks for carrier
   input wire logic col_req, // bench asks for collision
   input wire logic mdio_low, // bench asks phy to pull data low
   output logic crs_pin, // carrier sense
   output logic col_pin, // collision
   output logic mdio_pin // data pin
);
   always_ff @(posedge ref_clk) begin
      crs_pin <= crs_req;
      col_pin <= col_req & crs_req; // collision only under carrier
   end
   assign mdio_pin = ~mdio_low; // released line sits at its pull-up
endmodule

// ===== tb_top.sv
// self-checking bench for the mac control slice
`timescale 1ns/1ps
module tb_top;
   import emc_pkg::*;
   logic ref_clk, rst_b, avs_read, avs_write, mgmt_busy, tx_frame_done, tx_retry_limit;
   logic tx_dma_late, rx_frame_start, bit_tick, rx_da_valid, rx_da_bcast, rx_da_mcast;
   logic rx_da_match, rx_buf_advance, crs_req, col_req, mdio_pin, col_pin, crs_pin, mdc;
   logic avs_waitrequest, stats_write_enable, back_pressure_jam, full_duplex, tx_defer;
   logic speed_100, rx_accept, rx_accept_valid, single_slot, rmii_select, no_crc_append;
   logic tx_go, tx_oversize, tx_bad_fcs, mdio_low;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rx_buf_next, tx_buf_addr, rx_queue_ptr, q;
   logic [3:0] avs_byteenable;
   logic [2:0] tx_fifo_words;
   logic [5:0] rx_hash_idx;
   logic [63:0] hash_bits;
   logic [10:0] rx_len_limit, tx_frame_length;
   int n_fail, checked;
   emc_ctrl #(.FIFO_W(3)) uut (.*, .ce(1'b1));
   emc_phy_model phy (.*);
   initial begin
      ref_clk = 0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   task conclude;
      $display("fails %0d checks %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task wt(input int k);
      repeat (k) @(posedge ref_clk);
   endtask
   // holds the request until waitrequest is seen low
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do begin wt(1); n++; end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) begin n_fail++; conclude; end
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      wt(1);
   endtask
   task half(output int h);
      logic m;
      m = mdc;
      h = 0;
      do begin wt(1); h++; end while (mdc === m && h < 300);
      if (h >= 300) begin n_fail++; conclude; end
   endtask
   task da(input logic [31:0] c, input logic [2:0] bmm, input logic e);
      bus(1, OFS_CFG, c);
      {rx_da_bcast, rx_da_mcast, rx_da_match} <= bmm;
      rx_da_valid <= 1;
      wt(1);
      rx_da_valid <= 0;
      wt(1);
      chk(rx_accept, e);
   endtask
   task t_regs;
      bus(0, OFS_TSR, 0); chk(q, 32'h18);
      bus(0, OFS_CFG, 0); chk(q, CFG_RST);
      bus(0, OFS_SR, 0); chk(q & 32'h6, 32'h6);
      mgmt_busy <= 0;
      bus(0, OFS_SR, 0); chk(q & 32'h6, 32'h2);
      mdio_low <= 1;
      wt(3);
      bus(0, OFS_SR, 0); chk(q & 32'h6, 32'h0);
      mdio_low <= 0;
      bus(0, 8'h1C, 0); chk(q, 0);
      bus(1, OFS_CTL, 32'h180); bus(0, OFS_CTL, 0); chk(q, 32'h180);
      chk(stats_write_enable, 1);
   endtask
   task t_cfg;
      bus(1, OFS_CFG, 32'h3FF7); bus(0, OFS_CFG, 0); chk(q, 32'h3FF7);
      chk({full_duplex, single_slot, rmii_select, speed_100}, 4'hF);
      chk(rx_len_limit, RX_MAX_LONG);
      crs_req <= 1;
      wt(4); chk(tx_defer, 0);
      bus(1, OFS_CFG, CFG_RST); wt(4); chk(tx_defer, 1);
      chk(rx_len_limit, RX_MAX_STD);
      col_req <= 1;
      wt(4);
      col_req <= 0;
      crs_req <= 0;
      bus(0, OFS_TSR, 0); chk(q[TSR_COL], 1);
      bus(1, OFS_TSR, 32'h2); bus(0, OFS_TSR, 0); chk(q[TSR_COL], 0);
   endtask
   task t_mdc;
      int h;
      for (int c = 0; c < 4; c++) begin
         bus(1, OFS_CFG, CFG_RST & ~32'hC00 | 32'(c) << CFG_CLK_LSB);
         half(h);
         half(h);
         chk(h, 4 << c);
      end
   endtask
   task t_jam;
      int n;
      n = 0;
      bus(1, OFS_CFG, CFG_RST);
      bus(1, OFS_CTL, 32'h100);
      bit_tick <= 1;
      rx_frame_start <= 1;
      wt(1);
      rx_frame_start <= 0;
      repeat (100) begin wt(1); n += back_pressure_jam; end
      chk(n, 64);
      bit_tick <= 0;
      bus(1, OFS_CTL, 0);
   endtask
   task t_rx;
      da(32'h810, 3'b000, 1);
      da(32'h800, 3'b000, 0);
      da(32'h800, 3'b100, 1);
      da(32'h820, 3'b100, 0);
      da(32'h840, 3'b010, 1);
      da(32'h880, 3'b000, 1);
      rx_hash_idx <= 6'h06;
      da(32'h880, 3'b000, 0);
      rx_buf_next <= 32'h2003;
      rx_buf_advance <= 1;
      wt(1);
      rx_buf_advance <= 0;
      wt(2); chk(rx_queue_ptr, 32'h2000);
      bus(1, OFS_RBQP, 32'h3007); bus(0, OFS_RBQP, 0); chk(q, 32'h3004);
   endtask
   task t_tx;
      bus(1, OFS_TAR, 32'h1002); bus(1, OFS_TCR, 100);
      bus(0, OFS_TSR, 0); chk(q & 32'h18, 32'h10);
      chk(tx_buf_addr, 32'h1002); chk(tx_frame_length, 100);
      tx_fifo_words <= 2;
      wt(3); chk(tx_go, 1);
      bus(1, OFS_TAR, 32'h2000); bus(1, OFS_TCR, 32'h85EB);
      bus(0, OFS_TSR, 0); chk(q[TSR_FREE], 0);
      bus(1, OFS_TAR, 32'h3000); bus(0, OFS_TSR, 0); chk(q[TSR_OVERRUN], 1);
      bus(0, OFS_TAR, 0); chk(q, 32'h1002);
      bus(0, OFS_TCR, 0); chk(q, 32'd100);
      tx_dma_late <= 1;
      wt(1);
      tx_dma_late <= 0;
      wt(2); chk(tx_bad_fcs, 1);
      tx_frame_done <= 1;
      wt(1);
      tx_frame_done <= 0;
      wt(2); chk({tx_oversize, no_crc_append, tx_frame_length}, 13'h0DEB);
      chk(tx_buf_addr, 32'h2000);
      bus(0, OFS_TCR, 0); chk(q, 32'h85EB);
      tx_retry_limit <= 1;
      wt(1);
      tx_retry_limit <= 0;
      tx_frame_done <= 1;
      wt(1);
      tx_frame_done <= 0;
      bus(0, OFS_TSR, 0); chk(q, 32'h7D);
      bus(1, OFS_TSR, 32'h67); bus(0, OFS_TSR, 0); chk(q, 32'h18);
      bus(1, OFS_TAR, 0); bus(1, OFS_TCR, 1515); wt(2); chk(tx_oversize, 1);
   endtask
   initial begin
      {rst_b, avs_read, avs_write, tx_frame_done, tx_retry_limit, tx_dma_late} = '0;
      {rx_frame_start, bit_tick, rx_da_valid, rx_da_bcast, rx_da_mcast, rx_da_match} = '0;
      {rx_buf_advance, crs_req, col_req, avs_address, avs_writedata, rx_buf_next} = '0;
      mgmt_busy = 1;
      mdio_low = 0;
      avs_byteenable = 4'hF;
      tx_fifo_words = 3'h1;
      hash_bits = 64'h20;
      rx_hash_idx = 6'h05;
      n_fail = 0;
      checked = 0;
      wt(2);
      rst_b <= 1;
      wt(1);
      t_regs;
      t_cfg;
      t_mdc;
      t_jam;
      t_rx;
      t_tx;
      conclude;
   end
   initial begin
      #400000;
      n_fail++;
      conclude;
   end
endmodule
